// ===== src/ascd_cmd_decoder.sv
// Purpose: Serial command decoder and output formatter of a converter
// Assumes: sclk is the link clock; cs_n low frames each transfer
// Notes:   Link logic runs on sclk edges, control on clock
`timescale 1ns/100ps
module ascd_cmd_decoder (
    input  logic                                      clock,
    input  logic                                      sys_rst,
    input  logic                                      sclk,
    input  logic                                      cs_n,
    input  logic                                      din,
    output logic                                      dout,
    output logic                                      dout_oe,
    output logic                                      sample_ready_n,
    input  logic                                      sample_valid,
    input  logic [ascd_pkg::STAT_W-1:0]               status_word,
    input  logic [ascd_pkg::N_CH*ascd_pkg::RAW_W-1:0] chan_raw,
    output logic [ascd_pkg::RATE_W-1:0]               rate_select_field,
    output logic                                      standby,
    output logic                                      conv_running,
    output logic                                      zero_trim_pulse,
    output logic                                      filter_clear
);
    import ascd_pkg::*;

    // ==========================================
    // Functions
    function automatic logic [CODE_W-1:0] clip_code(
        input logic signed [RAW_W-1:0] raw,
        input logic                    is16
    );
        logic signed [RAW_W-1:0] v;
        logic [CODE_W-1:0]       res;
        v   = is16 ? (raw >>> SHIFT16) : raw;
        res = v[CODE_W-1:0];
        if (is16)
        begin
            res = {8'h00, v[CODE16_W-1:0]};
            if (v > LIM_HI16)
                res = {8'h00, LIM_HI16[CODE16_W-1:0]};
            else if (v < LIM_LO16)
                res = {8'h00, LIM_LO16[CODE16_W-1:0]};
        end
        else if (v > LIM_HI24)
            res = LIM_HI24[CODE_W-1:0];
        else if (v < LIM_LO24)
            res = LIM_LO24[CODE_W-1:0];
        return res;
    endfunction : clip_code

    // ==========================================
    // Declarations
    logic                link_rst;
    logic                frame_clr;
    logic                fall_tgl;
    logic [2:0]          bit_cnt;
    ascd_phase_e         phase;
    logic [7:0]          shift_in;
    logic                cmd_is_store;
    logic                rdata_armed;
    logic [4:0]          xfer_addr;
    logic [4:0]          xfer_left;
    logic [4:0]          fetch_addr;
    logic [7:0]          byte_now;
    logic [6:0]          op7;
    ascd_ev_e            sys_kind;
    logic                edge7;
    logic                edge8;
    logic                cont_mode;
    logic                ev_tgl;
    ascd_ev_e            ev_kind;
    logic [4:0]          ev_addr;
    logic [7:0]          ev_data;
    logic                ld_tgl;
    logic                ld_frame;
    logic [7:0]          ld_byte;
    logic                ld_seen;
    logic                ld_now;
    logic                ld_is_frame;
    logic [FRAME_W-1:0]  ld_src;
    logic [7:0]          ld_len;
    logic                reading;
    logic [FRAME_W-1:0]  out_shift;
    logic [7:0]          out_left;
    logic                ev_s;
    logic                fall_s;
    logic                reading_s;
    logic                ev_seen;
    logic                fall_seen;
    logic                ev_hit;
    logic                fall_hit;
    logic                rst_cmd;
    logic [7:0]          rst_cnt;
    logic [7:0]          reg_file [N_REGS];
    logic                is16_now;
    logic                frame_is16;
    logic                frame_pend;
    logic                load_go;
    logic [FRAME_W-1:0]  frame_hold;
    logic [FRAME_W-1:0]  next_frame;

    // ==========================================
    // Link reset and frame clear
    always_ff @(posedge clock)
    begin
        link_rst <= sys_rst;
    end

    assign frame_clr = cs_n | link_rst;

    // ==========================================
    // Link decode terms
    assign byte_now   = {shift_in[6:0], din};
    assign op7        = {shift_in[5:0], din};
    assign edge7      = (phase == PH_OPCODE) && (bit_cnt == BIT7_IDX);
    assign edge8      = (bit_cnt == BIT8_IDX);
    assign fetch_addr = (phase == PH_COUNT) ? xfer_addr : xfer_addr + 5'h01;

    // Seven bits pick the system and single read opcodes
    always_comb
    begin
        sys_kind = EV_NONE;
        unique case (op7)
            OP_EXIT_LP[7:1]: sys_kind = EV_EXIT_LP;
            OP_STBY[7:1]:    sys_kind = EV_STBY;
            OP_RESET[7:1]:   sys_kind = EV_RESET;
            OP_START[7:1]:   sys_kind = EV_START;
            OP_STOP[7:1]:    sys_kind = EV_STOP;
            OP_ZTRIM[7:1]:   sys_kind = EV_ZTRIM;
            default:         sys_kind = EV_NONE;
        endcase
    end

    // ==========================================
    // Falling edge counter, free of chip select
    always_ff @(negedge sclk or posedge link_rst)
    begin
        if (link_rst)
            fall_tgl <= 1'b0;
        else
            fall_tgl <= ~fall_tgl;
    end

    // ==========================================
    // Byte assembly and command phase
    always_ff @(negedge sclk or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            bit_cnt      <= 3'h0;
            phase        <= PH_OPCODE;
            shift_in     <= 8'h00;
            cmd_is_store <= 1'b0;
            rdata_armed  <= 1'b0;
            xfer_addr    <= 5'h00;
            xfer_left    <= 5'h00;
        end
        else
        begin
            shift_in <= byte_now;
            bit_cnt  <= bit_cnt + 3'h1;
            if (edge7)
                rdata_armed <= (op7 == OP_RDATA[7:1]);
            if (edge8)
            begin
                unique case (phase)
                    PH_OPCODE:
                    begin
                        if (byte_now[7:5] == OPC3_STORE ||
                            (byte_now[7:5] == OPC3_FETCH && !cont_mode))
                        begin
                            phase        <= PH_COUNT;
                            cmd_is_store <= (byte_now[7:5] == OPC3_STORE);
                            xfer_addr    <= byte_now[4:0];
                        end
                    end
                    PH_COUNT:
                    begin
                        if (byte_now[7:5] == CNT3)
                        begin
                            phase     <= cmd_is_store ? PH_STORE : PH_FETCH;
                            xfer_left <= byte_now[4:0];
                        end
                        else
                            phase <= PH_OPCODE;
                    end
                    PH_STORE, PH_FETCH:
                    begin
                        if (xfer_left == 5'h00)
                            phase <= PH_OPCODE;
                        else
                        begin
                            xfer_left <= xfer_left - 5'h01;
                            xfer_addr <= xfer_addr + 5'h01;
                        end
                    end
                endcase
            end
        end
    end

    // ==========================================
    // Mode, events and load requests on the link
    always_ff @(negedge sclk or posedge link_rst)
    begin
        if (link_rst)
        begin
            cont_mode <= 1'b1;
            ev_tgl    <= 1'b0;
            ev_kind   <= EV_NONE;
            ev_addr   <= 5'h00;
            ev_data   <= 8'h00;
            ld_tgl    <= 1'b0;
            ld_frame  <= 1'b0;
            ld_byte   <= 8'h00;
        end
        else
        begin
            if (edge7 && sys_kind != EV_NONE)
            begin
                ev_tgl  <= ~ev_tgl;
                ev_kind <= sys_kind;
            end
            if (phase == PH_OPCODE && edge8)
            begin
                if (byte_now == OP_CONT)
                    cont_mode <= 1'b1;
                if (byte_now == OP_HALT)
                    cont_mode <= 1'b0;
                if (rdata_armed)
                begin
                    ld_tgl   <= ~ld_tgl;
                    ld_frame <= 1'b1;
                end
            end
            if (phase == PH_STORE && edge8)
            begin
                ev_tgl  <= ~ev_tgl;
                ev_kind <= EV_WDATA;
                ev_addr <= xfer_addr;
                ev_data <= byte_now;
            end
            if (edge8 && ((phase == PH_COUNT && !cmd_is_store && byte_now[7:5] == CNT3)
                          || (phase == PH_FETCH && xfer_left != 5'h00)))
            begin
                ld_tgl   <= ~ld_tgl;
                ld_frame <= 1'b0;
                ld_byte  <= reg_file[fetch_addr];
            end
        end
    end

    // ==========================================
    // Output shifter on rising edges
    assign ld_now      = (ld_tgl != ld_seen) || (cont_mode && !dout_oe);
    assign ld_is_frame = (ld_tgl == ld_seen) || ld_frame;
    assign ld_src      = ld_is_frame ? frame_hold : {ld_byte, {(FRAME_W-8){1'b0}}};
    assign ld_len      = !ld_is_frame ? BYTE_LEN : (frame_is16 ? FRAME_LEN16 : FRAME_LEN24);

    always_ff @(posedge sclk or posedge link_rst)
    begin
        if (link_rst)
            ld_seen <= 1'b0;
        else
            ld_seen <= ld_tgl;
    end

    always_ff @(posedge sclk or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            reading   <= 1'b0;
            out_shift <= '0;
            out_left  <= 8'h00;
            dout      <= 1'b0;
        end
        else if (ld_now)
        begin
            dout      <= ld_src[FRAME_W-1];
            out_shift <= ld_src << 1;
            out_left  <= ld_len - 8'h01;
            reading   <= 1'b1;
        end
        else if (out_left != 8'h00)
        begin
            dout      <= out_shift[FRAME_W-1];
            out_shift <= out_shift << 1;
            out_left  <= out_left - 8'h01;
            reading   <= (out_left != 8'h01);
        end
        else
        begin
            dout    <= 1'b0;
            reading <= 1'b0;
        end
    end

    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
            dout_oe <= 1'b0;
        else
            dout_oe <= 1'b1;
    end

    // ==========================================
    // Crossings into the block clock
    ascd_sync u_ev_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .async_in (ev_tgl),
        .sync_out (ev_s)
    );

    ascd_sync u_fall_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .async_in (fall_tgl),
        .sync_out (fall_s)
    );

    ascd_sync u_read_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .async_in (reading),
        .sync_out (reading_s)
    );

    // Event payload is steady while the toggle settles
    assign ev_hit   = (ev_s != ev_seen);
    assign fall_hit = (fall_s != fall_seen);
    assign rst_cmd  = ev_hit && (ev_kind == EV_RESET);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            ev_seen   <= 1'b0;
            fall_seen <= 1'b0;
        end
        else
        begin
            ev_seen   <= ev_s;
            fall_seen <= fall_s;
        end
    end

    // ==========================================
    // Power, conversion and reset control
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            standby         <= 1'b0;
            conv_running    <= 1'b0;
            zero_trim_pulse <= 1'b0;
            filter_clear    <= 1'b0;
            rst_cnt         <= 8'h00;
        end
        else
        begin
            zero_trim_pulse <= ev_hit && (ev_kind == EV_ZTRIM);
            filter_clear    <= rst_cmd || (rst_cnt > 8'h01);
            if (ev_hit)
            begin
                unique case (ev_kind)
                    EV_EXIT_LP: standby      <= 1'b0;
                    EV_STBY:    standby      <= 1'b1;
                    EV_START:   conv_running <= 1'b1;
                    EV_STOP:    conv_running <= 1'b0;
                    EV_RESET:   rst_cnt      <= RESET_CYC;
                    EV_NONE, EV_ZTRIM, EV_WDATA:
                        rst_cnt <= rst_cnt;
                endcase
            end
            else if (rst_cnt != 8'h00)
                rst_cnt <= rst_cnt - 8'h01;
        end
    end

    // ==========================================
    // Configuration registers
    always_ff @(posedge clock)
    begin
        if (sys_rst || rst_cmd)
        begin
            for (int i = 0; i < N_REGS; i++)
                reg_file[i] <= REG_DEFAULT;
            reg_file[RATE_REG_ADDR] <= RATE_REG_DEFAULT;
        end
        else if (ev_hit && ev_kind == EV_WDATA)
            reg_file[ev_addr] <= ev_data;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            rate_select_field <= RATE_REG_DEFAULT[RATE_LSB +: RATE_W];
        else
            rate_select_field <= reg_file[RATE_REG_ADDR][RATE_LSB +: RATE_W];
    end

    // ==========================================
    // Frame formatting
    assign is16_now = (rate_select_field == RATE_16_LO) ||
                      (rate_select_field == RATE_16_HI);

    always_comb
    begin
        logic [CODE_W-1:0] code;
        code       = '0;
        next_frame = '0;
        next_frame[FRAME_W-1 -: STAT_W] = status_word;
        for (int i = 0; i < N_CH; i++)
        begin
            code = clip_code(signed'(chan_raw[i*RAW_W +: RAW_W]), is16_now);
            if (is16_now)
                next_frame[FRAME_W-STAT_W-1-CODE16_W*i -: CODE16_W] =
                    code[CODE16_W-1:0];
            else
                next_frame[FRAME_W-STAT_W-1-CODE_W*i -: CODE_W] = code;
        end
    end

    // New data waits while a readout is in flight
    assign load_go = (sample_valid || frame_pend) && !reading_s;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            frame_hold     <= '0;
            frame_is16     <= 1'b0;
            frame_pend     <= 1'b0;
            sample_ready_n <= 1'b1;
        end
        else
        begin
            frame_pend <= (sample_valid || frame_pend) && reading_s;
            if (load_go)
            begin
                frame_hold <= next_frame;
                frame_is16 <= is16_now;
            end
            if (load_go)
                sample_ready_n <= 1'b0;
            else if (fall_hit)
                sample_ready_n <= 1'b1;
        end
    end

endmodule : ascd_cmd_decoder

// ===== src/ascd_pkg.sv
// Purpose: Shared constants and types of the serial command decoder
// Assumes: The block clock is also the converter master clock
// Notes:   Opcodes, frame layout, clip limits and reset timing
package ascd_pkg;

    // ==========================================
    // Frame layout
    localparam int N_CH      = 8;
    localparam int STAT_W    = 24;
    localparam int CODE_W    = 24;
    localparam int CODE16_W  = 16;
    localparam int RAW_W     = 26;
    localparam int SHIFT16   = 8;
    localparam int FRAME_W   = STAT_W + N_CH * CODE_W;
    localparam int FRAME16_W = STAT_W + N_CH * CODE16_W;
    localparam logic [7:0] FRAME_LEN24 = 8'(FRAME_W);
    localparam logic [7:0] FRAME_LEN16 = 8'(FRAME16_W);
    localparam logic [7:0] BYTE_LEN    = 8'h08;

    // ==========================================
    // Clip limits, 24-bit pair in 24-bit code units, 16-bit pair in units after SHIFT16
    localparam logic signed [RAW_W-1:0] LIM_HI24 = 26'sh07F_FFFF;
    localparam logic signed [RAW_W-1:0] LIM_LO24 = 26'sh380_0000;
    localparam logic signed [RAW_W-1:0] LIM_HI16 = 26'sh000_7FFF;
    localparam logic signed [RAW_W-1:0] LIM_LO16 = 26'sh3FF_8000;

    // ==========================================
    // Opcodes
    localparam logic [7:0] OP_EXIT_LP = 8'h02;
    localparam logic [7:0] OP_STBY    = 8'h04;
    localparam logic [7:0] OP_RESET   = 8'h06;
    localparam logic [7:0] OP_START   = 8'h08;
    localparam logic [7:0] OP_STOP    = 8'h0A;
    localparam logic [7:0] OP_ZTRIM   = 8'h1A;
    localparam logic [7:0] OP_CONT    = 8'h10;
    localparam logic [7:0] OP_HALT    = 8'h11;
    localparam logic [7:0] OP_RDATA   = 8'h12;
    localparam logic [2:0] OPC3_FETCH = 3'b001;
    localparam logic [2:0] OPC3_STORE = 3'b010;
    localparam logic [2:0] CNT3       = 3'b000;
    localparam logic [2:0] BIT7_IDX   = 3'h6;
    localparam logic [2:0] BIT8_IDX   = 3'h7;

    // ==========================================
    // Configuration registers
    localparam int          N_REGS           = 32;
    localparam logic [4:0]  RATE_REG_ADDR    = 5'h01;
    localparam int          RATE_LSB         = 0;
    localparam int          RATE_W           = 3;
    localparam logic [7:0]  REG_DEFAULT      = 8'h00;
    localparam logic [7:0]  RATE_REG_DEFAULT = 8'h06;
    localparam logic [2:0]  RATE_16_LO       = 3'b000;
    localparam logic [2:0]  RATE_16_HI       = 3'b001;

    // ==========================================
    // Timing
    localparam int MCLK_PERIOD_NS = 20;
    localparam int CLK_PERIOD_NS  = 20;
    localparam int RESET_MASTER_CLOCK_PERIOD     = 18;
    localparam logic [7:0] RESET_CYC =
        8'((RESET_MASTER_CLOCK_PERIOD * MCLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ==========================================
    // Types
    typedef enum logic [2:0] {
        EV_NONE    = 3'h0,
        EV_EXIT_LP = 3'h1,
        EV_STBY    = 3'h2,
        EV_RESET   = 3'h3,
        EV_START   = 3'h4,
        EV_STOP    = 3'h5,
        EV_ZTRIM   = 3'h6,
        EV_WDATA   = 3'h7
    } ascd_ev_e;

    typedef enum logic [1:0] {
        PH_OPCODE = 2'b00,
        PH_COUNT  = 2'b01,
        PH_STORE  = 2'b11,
        PH_FETCH  = 2'b10
    } ascd_phase_e;

endpackage : ascd_pkg

// ===== src/ascd_sync.sv
// Purpose: Two-stage level synchroniser into the block clock
// Assumes: Input is a level or a toggle from another domain
// Notes:   First stage feeds only the second
`timescale 1ns/100ps
module ascd_sync (
    input  logic clock,
    input  logic sys_rst,
    input  logic async_in,
    output logic sync_out
);

    logic meta;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            meta     <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule : ascd_sync

// ===== verification/ascd_asserts.sv
// Purpose: Port checks of the command decoder
// Assumes: Block clock domain view of the ports
// Notes:   Bound from the bench top file
`timescale 1ns/100ps
module ascd_asserts (
    input logic                         clock,
    input logic                         sys_rst,
    input logic                         cs_n,
    input logic                         dout,
    input logic                         dout_oe,
    input logic                         sample_ready_n,
    input logic                         sample_valid,
    input logic [ascd_pkg::RATE_W-1:0]  rate_select_field,
    input logic                         standby,
    input logic                         conv_running,
    input logic                         zero_trim_pulse,
    input logic                         filter_clear
);
    logic [5:0] clr_cnt;
    logic [3:0] idle_cnt;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ====
    // Run length of clear and deselect time
    always_ff @(posedge clock)
        clr_cnt <= (sys_rst || !filter_clear) ? 6'h00 : clr_cnt + 6'h01;
    always_ff @(posedge clock)
        idle_cnt <= (sys_rst || !cs_n) ? 4'h0 : idle_cnt + {3'h0, idle_cnt != 4'hF};
    oe_off_idle_a: assert property (cs_n |-> !dout_oe)
        else $error("dout_oe high while deselected");
    dout_low_idle_a: assert property (cs_n |-> !dout)
        else $error("dout high while deselected");
    trim_one_a: assert property (zero_trim_pulse |=> !zero_trim_pulse)
        else $error("trim pulse too long");
    clear_len_a: assert property ($fell(filter_clear) |-> clr_cnt == 6'h12)
        else $error("filter clear length wrong");
    rate_restore_a: assert property ($rose(filter_clear) |-> ##[0:3] rate_select_field == 3'h6)
        else $error("rate not restored");
    reset_state_a: assert property ($fell(sys_rst) |-> !standby && !conv_running && sample_ready_n)
        else $error("bad state after reset");
    ready_low_a: assert property (sample_valid && cs_n |-> ##[1:3] !sample_ready_n)
        else $error("sample ready not lowered");
    idle_stable_a: assert property (idle_cnt > 4'h8 |-> $stable(standby) && $stable(conv_running))
        else $error("mode changed while deselected");
endmodule : ascd_asserts

// ===== verification/ascd_host.sv
// Purpose: Host side link master model
// Assumes: Link clock idles low, dout read on falls
// Notes:   Idle din shows the inverse of its last bit
`timescale 1ns/100ps
module ascd_host (
    output logic sclk,
    output logic cs_n,
    output logic din,
    input  logic dout
);
    logic [215:0] rx;
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
    end
    // ====
    // Framing and bit transfers
    task automatic sel();
        #7 cs_n = 1'b0;
    endtask : sel
    task automatic desel();
        #9 cs_n = 1'b1;
        din = ~din;
        #100;
    endtask : desel
    task automatic shift(input logic b);
        // Data moves mid-low, clear of the sampling fall
        #3 din = b;
        #3 sclk = 1'b1;
        #6 sclk = 1'b0;
        rx = {rx[214:0], dout};
    endtask : shift
    task automatic put(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            shift(b[i]);
        #100;
    endtask : put
    task automatic get(input int n);
        for (int i = 0; i < n; i++)
            shift(1'b0);
    endtask : get
endmodule : ascd_host

// ===== verification/testbench.sv
// Purpose: Self-checking bench of the command decoder
// Assumes: Host model drives the link
// Notes:   Inputs change on falling clock edges
`timescale 1ns/100ps
module testbench;
    import ascd_pkg::*;
    localparam logic [207:0] RAW = {26'h0, 26'h3FF_FF00, 26'h100, 26'h200_0000,
                                    26'h1FF_FFFF, 26'h0, 26'h3FF_FFFF, 26'h1};
    localparam logic [23:0] E24 [8] = '{24'h1, 24'hFF_FFFF, 24'h0, 24'h7F_FFFF,
                                        24'h80_0000, 24'h100, 24'hFF_FF00, 24'h0};
    localparam logic [15:0] E16 [8] = '{16'h0, 16'hFFFF, 16'h0, 16'h7FFF,
                                        16'h8000, 16'h1, 16'hFFFF, 16'h0};
    logic                  clock = 1'b0;
    logic                  sys_rst = 1'b1;
    logic                  sample_valid = 1'b0;
    logic [STAT_W-1:0]     status_word = 24'hA5_0F3C;
    logic [N_CH*RAW_W-1:0] chan_raw = RAW;
    logic [RATE_W-1:0]     rate_select_field;
    logic                  sclk, cs_n, din, dout, dout_oe, sample_ready_n;
    logic                  standby, conv_running, zero_trim_pulse, filter_clear;
    logic                  trim_seen = 1'b0;
    logic                  clr_seen = 1'b0;
    int                    n_fail = 0;
    int                    compares = 0;
    int                    cyc = 0;
    ascd_cmd_decoder uut (.clock, .sys_rst, .sclk, .cs_n, .din, .dout, .dout_oe,
        .sample_ready_n, .sample_valid, .status_word, .chan_raw, .rate_select_field,
        .standby, .conv_running, .zero_trim_pulse, .filter_clear);
    ascd_host host (.sclk, .cs_n, .din, .dout);
    always #10 clock = ~clock;
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        trim_seen <= trim_seen | (zero_trim_pulse === 1'b1);
        clr_seen <= clr_seen | (filter_clear === 1'b1);
        if (cyc == 20000)
        begin
            n_fail++;
            test_done();
        end
    end
    // ====
    // Shared tasks
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        if (n_fail == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    task automatic cmd(input logic [7:0] op);
        host.sel();
        host.put(op);
        host.desel();
        repeat (12) @(negedge clock);
    endtask : cmd
    task automatic load();
        @(negedge clock);
        sample_valid = 1'b1;
        @(negedge clock);
        sample_valid = 1'b0;
        repeat (4) @(negedge clock);
        chk(sample_ready_n, 1'b0);
    endtask : load
    task automatic frame_chk(input logic w16);
        for (int c = 0; c < 8; c++)
            if (w16)
                chk(host.rx[127-16*c -: 16], E16[c]);
            else
                chk(host.rx[191-24*c -: 24], E24[c]);
        chk(w16 ? host.rx[151:128] : host.rx[215:192], status_word);
    endtask : frame_chk
    // ====
    // Scenarios
    task automatic t_cont();
        load();
        host.sel();
        host.get(216);
        host.desel();
        frame_chk(1'b0);
        chk(sample_ready_n, 1'b1);
    endtask : t_cont
    task automatic t_regs();
        host.sel();
        host.put(8'h21);
        host.put(8'h00);
        host.get(8);
        host.desel();
        chk(host.rx[7:0], status_word[7:0]);
        cmd(8'h11);
        host.sel();
        host.put(8'h41);
        host.put(8'h01);
        host.put(8'h00);
        host.put(8'h5A);
        host.desel();
        chk(rate_select_field, 3'h0);
        host.sel();
        host.put(8'h21);
        host.put(8'h01);
        host.get(16);
        host.desel();
        chk(host.rx[15:0], 16'h005A);
    endtask : t_regs
    task automatic t_read16();
        load();
        host.sel();
        host.put(8'h12);
        host.get(152);
        host.desel();
        frame_chk(1'b1);
    endtask : t_read16
    task automatic t_cmds();
        logic [7:0] ops [6];
        logic [2:0] exp [6];
        ops = '{8'h04, 8'h02, 8'h08, 8'hFF, 8'h1A, 8'h0A};
        exp = '{3'h2, 3'h0, 3'h1, 3'h1, 3'h5, 3'h4};
        for (int i = 0; i < 6; i++)
        begin
            cmd(ops[i]);
            chk({trim_seen, standby, conv_running}, exp[i]);
        end
    endtask : t_cmds
    task automatic t_reset();
        cmd(8'h06);
        repeat (30) @(negedge clock);
        chk(clr_seen, 1'b1);
        chk(rate_select_field, 3'h6);
        chan_raw = '0;
        status_word = 24'h5A_C3F0;
        load();
        host.sel();
        host.put(8'h12);
        host.get(216);
        host.desel();
        for (int c = 0; c < 8; c++)
            chk(host.rx[191-24*c -: 24], 24'h00_0000);
        chk(host.rx[215:192], status_word);
    endtask : t_reset
    initial
    begin
        repeat (4) @(negedge clock);
        sys_rst = 1'b0;
        repeat (3) @(negedge clock);
        t_cont();
        t_regs();
        t_read16();
        t_cmds();
        t_reset();
        test_done();
    end
endmodule : testbench
bind ascd_cmd_decoder ascd_asserts chk_i (.clock, .sys_rst, .cs_n, .dout, .dout_oe,
    .sample_ready_n, .sample_valid, .rate_select_field, .standby, .conv_running,
    .zero_trim_pulse, .filter_clear);
